// >>> shared/pin_pump_pkg.sv
// Functional notes
// - mode 000: driver off, input buffer off
// - mode 001: drive output level, buffer off
// - mode 010: drive level, buffer on, readback
// - mode 011: input only, driver high impedance
// - mode 100: driver off, input buffer off
// - other mode codes act as high impedance
// - output level bit sets pin level, resets 0
// - input level bit reads live pin state, 0 while the input buffer is off
// - pull-down enabled after reset, writable
// - reset values 0x0008, 0x0000, 0x0000
// - source leakage compensation follows its bit
// - sink leakage compensation follows its bit
// - pump enable bit drives charge pump
package pin_pump_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_PIN_D_CONFIG = 8'h38;
  localparam logic [7:0]  ADDR_FET_LEAK     = 8'h39;
  localparam logic [7:0]  ADDR_PUMP_CTRL    = 8'h3A;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int          POS_MODE_LO       = 0;
  localparam int          POS_PULLDOWN      = 3;
  localparam int          POS_OUT_LEVEL     = 4;
  localparam int          POS_IN_LEVEL      = 5;
  localparam int          POS_SINK_COMP     = 0;
  localparam int          POS_SRC_COMP      = 1;
  localparam int          POS_PUMP_EN       = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_PIN_D_CONFIG  = 16'h0008;
  localparam logic [15:0] RST_FET_LEAK      = 16'h0000;
  localparam logic [15:0] RST_PUMP_CTRL     = 16'h0000;

  // ----------------------------------------------------------------
  // pin mode codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_HIGH_Z   = 3'h0,
    MODE_OUTPUT   = 3'h1,
    MODE_OUT_IN   = 3'h2,
    MODE_INPUT    = 3'h3,
    MODE_FET_OFF  = 3'h4
  } pin_mode_t;

  // register port request
  typedef struct packed {
    logic        wr;     // write strobe
    logic        rd;     // read strobe
    logic [7:0]  addr;   // register address
    logic [15:0] wdata;  // write data
  } reg_req_t;

  // pad control toward the pin cell
  typedef struct packed {
    logic        drive_en;  // output driver on
    logic        drive_lvl; // driven level
    logic        ibuf_en;   // input buffer on
    logic        pd_en;     // weak pull-down on
  } pad_ctrl_t;

endpackage : pin_pump_pkg

// >>> hw/pad_mode_decode.sv
`timescale 1ns/1ns
// decodes the pin mode field into pad controls, registered
module pad_mode_decode (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // configuration
  input  wire logic [2:0]              mode,
  input  wire logic                    out_level,
  input  wire logic                    pulldown_en,
  // pad control
  output pin_pump_pkg::pad_ctrl_t      pad
);
  import pin_pump_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    pad_ctrl_t pad;
  } dec_state_t;

  dec_state_t st_r;   // registered controls
  dec_state_t st_nxt; // next value

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt               = st_r;
    st_nxt.pad.pd_en     = pulldown_en;
    unique case (mode)
      MODE_OUTPUT: begin
        st_nxt.pad.drive_en = 1'b1;
        st_nxt.pad.ibuf_en  = 1'b0;
      end
      MODE_OUT_IN: begin
        st_nxt.pad.drive_en = 1'b1;
        st_nxt.pad.ibuf_en  = 1'b1;
      end
      MODE_INPUT: begin
        st_nxt.pad.drive_en = 1'b0;
        st_nxt.pad.ibuf_en  = 1'b1;
      end
      MODE_FET_OFF: begin
        st_nxt.pad.drive_en = 1'b0;
        st_nxt.pad.ibuf_en  = 1'b0;
      end
      // 000 and reserved codes fall back to high impedance
      default: begin
        st_nxt.pad.drive_en = 1'b0;
        st_nxt.pad.ibuf_en  = 1'b0;
      end
    endcase
    // level forced low while the driver is off, so the pad output is a plain flop
    st_nxt.pad.drive_lvl = out_level & st_nxt.pad.drive_en;
  end

  // ----------------------------------------------------------------
  // register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '{pad: '{drive_en: 1'b0, drive_lvl: 1'b0, ibuf_en: 1'b0,
                       pd_en: RST_PIN_D_CONFIG[POS_PULLDOWN]}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pad = st_r.pad;

  // driver on exactly for the two output modes
  chk_drive_modes: assert property (@(posedge clk) disable iff (sys_rst)
    1 |=> pad.drive_en == ($past(mode) inside {MODE_OUTPUT, MODE_OUT_IN}))
    else $error("driver enable does not match mode");
  // input buffer on exactly for readback and input modes
  chk_ibuf_modes: assert property (@(posedge clk) disable iff (sys_rst)
    1 |=> pad.ibuf_en == ($past(mode) inside {MODE_OUT_IN, MODE_INPUT}))
    else $error("input buffer enable does not match mode");
  // reserved codes leave driver and input buffer off
  chk_reserved_hiz: assert property (@(posedge clk) disable iff (sys_rst)
    (mode > MODE_FET_OFF) |=> !pad.drive_en && !pad.ibuf_en)
    else $error("reserved mode not high impedance");

endmodule // pad_mode_decode

// >>> hw/pin_pump_regs.sv
`timescale 1ns/1ns
// register bank: pin d configuration, fet leakage compensation, pump
module pin_pump_regs (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // register port from the serial interface logic
  input  pin_pump_pkg::reg_req_t       req,
  output logic [15:0]                  rdata,
  output logic                         rvalid,
  // pin d pad
  input  wire logic                    pin_in,
  output logic                         pin_out,
  output logic                         pin_oe,
  output logic                         pin_ibuf_en,
  output logic                         pin_pd_en,
  // analog controls
  output logic                         source_leak_comp_enable,
  output logic                         sink_leak_comp_enable,
  output logic                         pump_enable_bit
);
  import pin_pump_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  mode;          // pin mode field
    logic        output_level_bit;
    logic        pulldown_enable_bit;
    logic        src_comp;
    logic        snk_comp;
    logic        pump;
    logic [1:0]  pin_sync;      // [0] first stage, [1] second stage
    logic        input_level_bit;
    logic [15:0] rdata;
    logic        rvalid;
  } regs_state_t;

  regs_state_t st_r;   // current state
  regs_state_t st_nxt; // next state
  pad_ctrl_t   pad;    // decoded pad controls

  // pack a register image; reserved bits forced to zero
  function automatic logic [15:0] read_word(input regs_state_t s, input logic [7:0] a);
    logic [15:0] w;
    w = 16'h0000;
    unique case (a)
      ADDR_PIN_D_CONFIG: begin
        w[POS_MODE_LO +: 3] = s.mode;
        w[POS_PULLDOWN]     = s.pulldown_enable_bit;
        w[POS_OUT_LEVEL]    = s.output_level_bit;
        w[POS_IN_LEVEL]     = s.input_level_bit;
      end
      ADDR_FET_LEAK: begin
        w[POS_SRC_COMP]     = s.src_comp;
        w[POS_SINK_COMP]    = s.snk_comp;
      end
      ADDR_PUMP_CTRL: begin
        w[POS_PUMP_EN]      = s.pump;
      end
      default: w = 16'h0000;                         // unmapped reads zero
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt          = st_r;
    // pin passes two flops; only the second stage is read
    st_nxt.pin_sync = {st_r.pin_sync[0], pin_in};
    // live level, seen only while the input buffer is on
    st_nxt.input_level_bit = st_r.pin_sync[1] & pad.ibuf_en;
    st_nxt.rvalid   = req.rd;
    st_nxt.rdata    = req.rd ? read_word(st_r, req.addr) : 16'h0000;
    if (req.wr) begin
      // only defined fields are stored; the rest is dropped
      unique case (req.addr)
        ADDR_PIN_D_CONFIG: begin
          st_nxt.mode                = req.wdata[POS_MODE_LO +: 3];
          st_nxt.pulldown_enable_bit = req.wdata[POS_PULLDOWN];
          st_nxt.output_level_bit    = req.wdata[POS_OUT_LEVEL];
        end
        ADDR_FET_LEAK: begin
          // no interlock: the host keeps outputs disabled meanwhile
          st_nxt.src_comp = req.wdata[POS_SRC_COMP];
          st_nxt.snk_comp = req.wdata[POS_SINK_COMP];
        end
        ADDR_PUMP_CTRL: begin
          st_nxt.pump = req.wdata[POS_PUMP_EN];
        end
        default: begin
          st_nxt.pump = st_r.pump;                               // unmapped ignored
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r.mode                <= RST_PIN_D_CONFIG[POS_MODE_LO +: 3];
      st_r.pulldown_enable_bit <= RST_PIN_D_CONFIG[POS_PULLDOWN];
      st_r.output_level_bit    <= RST_PIN_D_CONFIG[POS_OUT_LEVEL];
      st_r.input_level_bit     <= RST_PIN_D_CONFIG[POS_IN_LEVEL];
      st_r.src_comp            <= RST_FET_LEAK[POS_SRC_COMP];
      st_r.snk_comp            <= RST_FET_LEAK[POS_SINK_COMP];
      st_r.pump                <= RST_PUMP_CTRL[POS_PUMP_EN];
      st_r.pin_sync            <= 2'h0;
      st_r.rdata               <= 16'h0000;
      st_r.rvalid              <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pad decode; registered, so pad outputs lag the write by two edges
  // ----------------------------------------------------------------
  pad_mode_decode u_decode (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .mode      (st_r.mode),
    .out_level (st_r.output_level_bit),
    .pulldown_en (st_r.pulldown_enable_bit),
    .pad       (pad)
  );

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  assign rdata                   = st_r.rdata;
  assign rvalid                  = st_r.rvalid;
  assign pin_out                 = pad.drive_lvl;
  assign pin_oe                  = pad.drive_en;
  assign pin_ibuf_en             = pad.ibuf_en;
  assign pin_pd_en               = pad.pd_en;
  assign source_leak_comp_enable = st_r.src_comp;
  assign sink_leak_comp_enable   = st_r.snk_comp;
  assign pump_enable_bit         = st_r.pump;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_cfg_write;
    req.wr && req.addr == ADDR_PIN_D_CONFIG;
  endsequence

  // written level shows on the pin two edges later in output mode
  chk_out_level: assert property (@(posedge clk) disable iff (sys_rst)
    s_cfg_write ##0 (req.wdata[2:0] == 3'h1) |=> 1 ##1 (pin_oe && pin_out == $past(req.wdata[4], 2)))
    else $error("output level not driven");
  chk_pump_write: assert property (@(posedge clk) disable iff (sys_rst)
    req.wr && req.addr == ADDR_PUMP_CTRL |=> pump_enable_bit == $past(req.wdata[0]))
    else $error("pump enable not updated");
  chk_src_write: assert property (@(posedge clk) disable iff (sys_rst)
    req.wr && req.addr == ADDR_FET_LEAK |=> source_leak_comp_enable == $past(req.wdata[1]))
    else $error("source compensation not updated");
  chk_snk_write: assert property (@(posedge clk) disable iff (sys_rst)
    req.wr && req.addr == ADDR_FET_LEAK |=> sink_leak_comp_enable == $past(req.wdata[0]))
    else $error("sink compensation not updated");
  chk_pd_write: assert property (@(posedge clk) disable iff (sys_rst)
    s_cfg_write |=> 1 ##1 pin_pd_en == $past(req.wdata[3], 2))
    else $error("pull-down enable not updated");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
    rvalid |-> rdata[15:6] == 10'h000)
    else $error("reserved bits read nonzero");
  chk_reset_vals: assert property (@(posedge clk)
    $past(sys_rst) |-> st_r.pulldown_enable_bit && !st_r.pump && st_r.mode == 3'h0)
    else $error("reset value wrong");
  chk_ibuf_gate: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(pad.ibuf_en) |-> !st_r.input_level_bit)
    else $error("input level seen with buffer off");

endmodule // pin_pump_regs

// >>> sim/host_model.sv
`timescale 1ns/1ns
// host side of the parallel register port: one-cycle strobes, answer sampled
// at the edge after the strobe is taken
module host_model (
  // clock
  input  wire logic              clk,
  // register port
  output pin_pump_pkg::reg_req_t req,
  input  wire logic [15:0]       rdata,
  input  wire logic              rvalid
);
  import pin_pump_pkg::*;

  // idle port at time zero, no strobes
  initial req = '0;

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // one write; address and data are inverted on release so that a design
  // latching them late sees garbage rather than a lucky copy
  task automatic do_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // one read; the answer must stand at exactly the next edge
  task automatic do_read(input logic [7:0] a, output logic [15:0] d, output logic ok);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'hA5A5};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'h5A5A};
    @(posedge clk);
    ok = (rvalid === 1'b1);
    d = rdata;
  endtask
endmodule // host_model

// >>> sim/pin_d_fet_pump_config_regs_tb.sv
`timescale 1ns/1ns
module pin_d_fet_pump_config_regs_tb;
  import pin_pump_pkg::*;

  logic                   clk;         // 100 MHz clock
  logic                   sys_rst;     // sync reset
  logic                   ext_lvl;     // level an outside source puts on the pad
  pin_pump_pkg::reg_req_t req;         // register port
  logic [15:0]            rdata;       // read data
  logic                   rvalid;      // read answer
  logic                   pin_out, pin_oe, pin_ibuf_en, pin_pd_en;
  logic                   src_c, snk_c, pump;
  wire                    pin_wire;    // resolved pad level
  int                     miscompares; // mismatch count
  int                     n_tests;     // comparison count
  int                     i;
  logic [31:0]            seed;
  logic [15:0]            wv;

  // pad: device driver wins, else the pull-down, else the outside source
  assign pin_wire = pin_oe ? pin_out : (pin_pd_en ? 1'b0 : ext_lvl);

  host_model host_u (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

  pin_pump_regs dut_u (
    .clk(clk), .sys_rst(sys_rst), .req(req), .rdata(rdata), .rvalid(rvalid),
    .pin_in(pin_wire), .pin_out(pin_out), .pin_oe(pin_oe), .pin_ibuf_en(pin_ibuf_en),
    .pin_pd_en(pin_pd_en), .source_leak_comp_enable(src_c),
    .sink_leak_comp_enable(snk_c), .pump_enable_bit(pump));

  // ----------------------------------------------------------------
  // expectations and checks
  // ----------------------------------------------------------------
  function automatic logic exp_oe(logic [2:0] m);
    return (m == 3'h1) || (m == 3'h2);
  endfunction

  function automatic logic exp_ib(logic [2:0] m);
    return (m == 3'h2) || (m == 3'h3);
  endfunction

  // read image: live level only while the input buffer is on
  function automatic logic [15:0] exp_img(logic [15:0] w, logic x);
    logic lv;
    lv = exp_oe(w[2:0]) ? w[4] : (w[3] ? 1'b0 : x);
    return {10'h000, exp_ib(w[2:0]) & lv, w[4:0]};
  endfunction

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    logic        ok;
    host_u.do_read(a, v, ok);
    check("rvalid", 16'(ok), 16'h0001);
    check("rdata", v, exp);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h0B3D;
    sys_rst = 1'b1;
    ext_lvl = 1'b0;
    miscompares = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk(ADDR_PIN_D_CONFIG, 16'h0008);
    rd_chk(ADDR_FET_LEAK, 16'h0000);
    rd_chk(ADDR_PUMP_CTRL, 16'h0000);
    check("pd_en", 16'(pin_pd_en), 16'h0001);
    check("oe", 16'(pin_oe), 16'h0000);
    // all ones: reserved bits must drop; pin is still high impedance here
    host_u.do_write(ADDR_FET_LEAK, 16'hFFFF);
    host_u.do_write(ADDR_PUMP_CTRL, 16'hFFFF);
    @(posedge clk);
    check("src", 16'(src_c), 16'h0001);
    check("sink", 16'(snk_c), 16'h0001);
    check("pump", 16'(pump), 16'h0001);
    rd_chk(ADDR_FET_LEAK, 16'h0003);
    rd_chk(ADDR_PUMP_CTRL, 16'h0001);
    host_u.do_write(ADDR_FET_LEAK, 16'hFFFD);
    host_u.do_write(ADDR_PUMP_CTRL, 16'hFFFE);
    @(posedge clk);
    check("src", 16'(src_c), 16'h0000);
    check("sink", 16'(snk_c), 16'h0001);
    check("pump", 16'(pump), 16'h0000);
    // every mode code, three times, with random level, pull-down and pad
    for (i = 0; i < 24; i++) begin
      wv = 16'($random(seed));
      wv[2:0] = i[2:0];
      ext_lvl <= 1'($random(seed));
      host_u.do_write(ADDR_PIN_D_CONFIG, wv);
      repeat (5) @(posedge clk);
      check("oe", 16'(pin_oe), 16'(exp_oe(wv[2:0])));
      check("ibuf", 16'(pin_ibuf_en), 16'(exp_ib(wv[2:0])));
      check("out", 16'(pin_out), 16'(exp_oe(wv[2:0]) & wv[4]));
      check("pd_en", 16'(pin_pd_en), 16'(wv[3]));
      rd_chk(ADDR_PIN_D_CONFIG, exp_img(wv, ext_lvl));
    end
    // unmapped neighbours answer zero
    rd_chk(8'h37, 16'h0000);
    rd_chk(8'h3B, 16'h0000);
    // input mode, pull-down off: the bit follows the outside level live
    ext_lvl <= 1'b1;
    host_u.do_write(ADDR_PIN_D_CONFIG, 16'h0003);
    repeat (5) @(posedge clk);
    rd_chk(ADDR_PIN_D_CONFIG, 16'h0023);
    ext_lvl <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(ADDR_PIN_D_CONFIG, 16'h0003);
    // reset in mid-run restores the defaults; the write must land first
    host_u.do_write(ADDR_PUMP_CTRL, 16'h0001);
    @(posedge clk);
    check("pump", 16'(pump), 16'h0001);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk(ADDR_PIN_D_CONFIG, 16'h0008);
    check("pump", 16'(pump), 16'h0000);
    check("sink", 16'(snk_c), 16'h0000);
    check("pd_en", 16'(pin_pd_en), 16'h0001);
    check("oe", 16'(pin_oe), 16'h0000);
    tally_and_finish();
  end
endmodule // pin_d_fet_pump_config_regs_tb
